// ===== rtl/tarsb_pkg.sv
package tarsb_pkg;
  // Register page offsets
  localparam logic [5:0] OFS_STATUS = 6'h01;
  localparam logic [5:0] OFS_BUFCTL = 6'h02;
  // Status register fields
  localparam int POS_PIN_MODE = 14;
  localparam logic [1:0] RST_PIN_MODE = 2'h2;
  localparam logic [15:0] FLAG_MASK = 16'h07de;
  // Buffer control fields
  localparam int POS_BUF_EN = 15;
  localparam int POS_ONESHOT = 14;
  localparam int POS_LEVEL = 11;
  localparam int POS_FULL = 10;
  localparam int POS_EMPTY = 9;
  localparam logic RST_BUF_EN = 1'b0;
  localparam logic RST_ONESHOT = 1'b0;
  localparam logic [2:0] RST_LEVEL = 3'h0;
  // Result buffer sizing
  localparam logic [6:0] BUF_ENTRIES = 7'h40;
  localparam logic [6:0] TRIG_STEP = 7'h08;
  localparam int MEM_AW = 7;
  localparam int DATA_W = 16;
  localparam logic [2:0] KIND_PAGE = 3'h4;
  // Pin mode encodings
  typedef enum logic [1:0] {
    TARSB_PIN_PEN = 2'b00,
    TARSB_PIN_DAV = 2'b01,
    TARSB_PIN_BOTH = 2'b10,
    TARSB_PIN_BOTH2 = 2'b11
  } tarsb_pin_mode_t;
  // Result kinds
  typedef enum logic [3:0] {
    TARSB_K_X = 4'h0,
    TARSB_K_Y = 4'h1,
    TARSB_K_Z1 = 4'h2,
    TARSB_K_Z2 = 4'h3,
    TARSB_K_BAT = 4'h4,
    TARSB_K_AUX1 = 4'h5,
    TARSB_K_AUX2 = 4'h6,
    TARSB_K_T1 = 4'h7,
    TARSB_K_T2 = 4'h8
  } tarsb_kind_t;
endpackage : tarsb_pkg

// ===== rtl/tarsb_mem_if.sv
`timescale 1ns/10ps
interface tarsb_mem_if #(parameter int AW = 7, parameter int DW = 16);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr,
    input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr,
    output rd_data);
endinterface : tarsb_mem_if

// ===== rtl/tarsb_mem.sv
`timescale 1ns/10ps
module tarsb_mem #(
  parameter int AW = 7,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Port from the controller
  tarsb_mem_if.mem mp
);
  import tarsb_pkg::*;

  if (AW < 7 || DW < 1) begin : g_bad_size
    $error("tarsb_mem: needs AW >= 7 and DW >= 1");
  end

  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rd_data_ff;

  // Array holds no reset; only the read register does
  always_ff @(posedge mclk) begin
    if (mp.wr_en) begin
      mem_q[mp.wr_addr] <= mp.wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= '0;
    end else if (mp.rd_en) begin
      rd_data_ff <= mem_q[mp.rd_addr];
    end
  end

  assign mp.rd_data = rd_data_ff;
endmodule : tarsb_mem

// ===== rtl/tarsb_top.sv
`timescale 1ns/10ps
// Contract
// - X flag sets on store, clears on read
// - Y flag sets on store, clears on read
// - Z1 flag sets on store, clears on read
// - Z2 flag sets on store, clears on read
// - Battery flag sets on store, clears on read
// - AUX1 flag sets on store, clears on read
// - AUX2 flag sets on store, clears on read
// - TEMP1 flag sets on store, clears on read
// - TEMP2 flag sets on store, clears on read
// - Per-result flags meaningless in buffer mode
// - Enable 0 disables buffer, clears pointers
// - Mode bit: 0 continuous, 1 single-shot
// - Trigger code selects 8 to 64 entries
// - Full flag when 64 unread results
// - Empty flag when none unread, resets 1
// - Data-available pin low until results read; in buffer mode it goes high once unread results fall below the trigger depth
module tarsb_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Converter results
  input wire logic res_valid,
  input wire tarsb_pkg::tarsb_kind_t res_kind,
  input wire logic [tarsb_pkg::DATA_W-1:0] res_data,
  output logic res_ready,
  // Host result reads
  input wire logic res_rd,
  input wire tarsb_pkg::tarsb_kind_t res_rd_kind,
  output logic [tarsb_pkg::DATA_W-1:0] res_rdata,
  output logic res_rvalid,
  // Host register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Pins and converter control
  input wire logic pen_touch_n,
  output logic touch_or_data_ready_pin_n,
  output logic conv_hold
);
  import tarsb_pkg::*;

  typedef struct packed {
    logic [1:0] pin_mode;
    logic buffer_enable_ptr_clear;
    logic buffer_oneshot_select;
    logic [2:0] buffer_trigger_depth;
    logic [15:0] flags;
    logic [5:0] buffer_read_pointer;
    logic [5:0] buffer_write_pointer;
    logic [5:0] buffer_trigger_pointer;
    logic [6:0] cnt;
    logic [1:0] sk_cnt;
    logic [DATA_W+3:0] sk0;
    logic [DATA_W+3:0] sk1;
    logic in_ready;
    logic rd_pend;
    logic [DATA_W-1:0] res_rdata;
    logic res_rvalid;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic pin_n;
    logic hold;
    logic pen_s1;
    logic pen_s2;
  } tarsb_state_t;

  tarsb_state_t state_ff;
  tarsb_state_t nxt_state;

  tarsb_mem_if #(.AW(MEM_AW), .DW(DATA_W)) mem_bus ();

  tarsb_mem #(.AW(MEM_AW), .DW(DATA_W)) u_mem (
    .mclk(mclk),
    .rstn(rstn),
    .mp(mem_bus.mem)
  );

  // Per-kind slots sit on a page above the 64 buffer slots
  if (MEM_AW != 7) begin : g_bad_aw
    $error("tarsb_top: memory address must be 7 bits");
  end
  // Trigger codes must step exactly up to the buffer depth
  if (int'(TRIG_STEP) * 8 != int'(BUF_ENTRIES)) begin : g_bad_depth
    $error("tarsb_top: trigger step does not reach the buffer depth");
  end

  // Status bit position of each result kind; unknown kinds hit reserved D0
  function automatic logic [3:0] flag_pos(input logic [3:0] kind);
    case (kind)
      TARSB_K_X: flag_pos = 4'ha;
      TARSB_K_Y: flag_pos = 4'h9;
      TARSB_K_Z1: flag_pos = 4'h8;
      TARSB_K_Z2: flag_pos = 4'h7;
      TARSB_K_BAT: flag_pos = 4'h6;
      TARSB_K_AUX1: flag_pos = 4'h4;
      TARSB_K_AUX2: flag_pos = 4'h3;
      TARSB_K_T1: flag_pos = 4'h2;
      TARSB_K_T2: flag_pos = 4'h1;
      default: flag_pos = 4'h0;
    endcase
  endfunction : flag_pos

  // Trigger code n asks for (n + 1) * 8 unread entries
  function automatic logic [6:0] trig_depth(input logic [2:0] code);
    trig_depth = 7'({code, 3'h0}) + TRIG_STEP;
  endfunction : trig_depth

  function automatic logic [15:0] status_word(input logic [1:0] mode,
      input logic [15:0] flags);
    status_word = {mode, 14'h0000} | (flags & FLAG_MASK);
  endfunction : status_word

  // Full and empty come from one count, so they never disagree
  function automatic logic [15:0] bufctl_word(input logic en, input logic one,
      input logic [2:0] lvl, input logic [6:0] cnt);
    bufctl_word = 16'h0000;
    bufctl_word[POS_BUF_EN] = en;
    bufctl_word[POS_ONESHOT] = one;
    bufctl_word[POS_LEVEL +: 3] = lvl;
    bufctl_word[POS_FULL] = (cnt == BUF_ENTRIES);
    bufctl_word[POS_EMPTY] = (cnt == 7'h00);
  endfunction : bufctl_word

  // Active low pin; any enabled cause pulls it down
  function automatic logic pin_level_n(input logic [1:0] mode, input logic dav, input logic pen);
    case (mode)
      TARSB_PIN_PEN: pin_level_n = !pen;
      TARSB_PIN_DAV: pin_level_n = !dav;
      TARSB_PIN_BOTH: pin_level_n = !(dav || pen);
      TARSB_PIN_BOTH2: pin_level_n = !(dav || pen);
      default: pin_level_n = 1'b1;
    endcase
  endfunction : pin_level_n

  always_comb begin
    logic acc;
    logic drain;
    logic pop;
    logic dav;
    logic pen_low;
    logic [1:0] sk_nxt;
    logic [6:0] depth;
    logic [3:0] head_kind;
    acc = 1'b0;
    drain = 1'b0;
    pop = 1'b0;
    dav = 1'b0;
    pen_low = 1'b0;
    sk_nxt = '0;
    depth = '0;
    head_kind = '0;
    nxt_state = state_ff;

    // Pen pin synchroniser
    nxt_state.pen_s1 = pen_touch_n;
    nxt_state.pen_s2 = state_ff.pen_s1;
    pen_low = !state_ff.pen_s2;

    depth = trig_depth(state_ff.buffer_trigger_depth);
    head_kind = state_ff.sk0[DATA_W+3:DATA_W];

    // Two-entry skid buffer; a full result buffer stalls the drain
    acc = res_valid && state_ff.in_ready;
    drain = (state_ff.sk_cnt != 2'h0) &&
      (!state_ff.buffer_enable_ptr_clear || state_ff.cnt != BUF_ENTRIES);
    sk_nxt = state_ff.sk_cnt;
    if (drain) begin
      nxt_state.sk0 = state_ff.sk1;
      sk_nxt = sk_nxt - 2'h1;
    end
    if (acc) begin
      if (sk_nxt == 2'h0) begin
        nxt_state.sk0 = {res_kind, res_data};
      end else begin
        nxt_state.sk1 = {res_kind, res_data};
      end
      sk_nxt = sk_nxt + 2'h1;
    end
    nxt_state.sk_cnt = sk_nxt;
    // Ready is registered, so no path runs from valid back to ready
    nxt_state.in_ready = (sk_nxt != 2'h2);

    // Store: buffer slot in buffer mode, per-kind slot otherwise
    mem_bus.wr_en = drain;
    mem_bus.wr_data = state_ff.sk0[DATA_W-1:0];
    mem_bus.wr_addr = state_ff.buffer_enable_ptr_clear ?
      {1'b0, state_ff.buffer_write_pointer} : {KIND_PAGE, head_kind};

    // Host result read
    // An empty buffer read returns a stale word and leaves the pointer
    pop = res_rd && state_ff.buffer_enable_ptr_clear && (state_ff.cnt != 7'h00);
    mem_bus.rd_en = res_rd;
    mem_bus.rd_addr = state_ff.buffer_enable_ptr_clear ?
      {1'b0, state_ff.buffer_read_pointer} : {KIND_PAGE, res_rd_kind};
    nxt_state.rd_pend = res_rd;
    nxt_state.res_rvalid = state_ff.rd_pend;
    if (state_ff.rd_pend) begin
      nxt_state.res_rdata = mem_bus.rd_data;
    end

    // Flags live only outside buffer mode; a store in the read cycle wins
    if (res_rd && !state_ff.buffer_enable_ptr_clear) begin
      nxt_state.flags[flag_pos(res_rd_kind)] = 1'b0;
    end
    if (drain && !state_ff.buffer_enable_ptr_clear) begin
      nxt_state.flags[flag_pos(head_kind)] = 1'b1;
    end
    nxt_state.flags = nxt_state.flags & FLAG_MASK;

    // Buffer pointers and fill count
    if (drain && state_ff.buffer_enable_ptr_clear) begin
      nxt_state.buffer_write_pointer = state_ff.buffer_write_pointer + 6'h01;
    end
    if (pop) begin
      nxt_state.buffer_read_pointer = state_ff.buffer_read_pointer + 6'h01;
    end
    nxt_state.cnt = state_ff.cnt + 7'((drain && state_ff.buffer_enable_ptr_clear) ? 1 : 0)
      - 7'(pop ? 1 : 0);

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_STATUS: begin
          nxt_state.pin_mode = reg_wdata[POS_PIN_MODE +: 2];
        end
        OFS_BUFCTL: begin
          nxt_state.buffer_enable_ptr_clear = reg_wdata[POS_BUF_EN];
          nxt_state.buffer_oneshot_select = reg_wdata[POS_ONESHOT];
          nxt_state.buffer_trigger_depth = reg_wdata[POS_LEVEL +: 3];
          if (!reg_wdata[POS_BUF_EN]) begin
            nxt_state.buffer_read_pointer = '0;
            nxt_state.buffer_write_pointer = '0;
            nxt_state.cnt = '0;
          end
        end
        default: begin
        end
      endcase
    end
    nxt_state.buffer_trigger_pointer = nxt_state.buffer_read_pointer + depth[5:0];

    // Single-shot stops conversions at trigger until drained
    if (!nxt_state.buffer_enable_ptr_clear || !nxt_state.buffer_oneshot_select ||
        nxt_state.cnt == 7'h00) begin
      nxt_state.hold = 1'b0;
    end else if (nxt_state.cnt >= depth) begin
      nxt_state.hold = 1'b1;
    end

    // Per-result flags are ignored for signalling in buffer mode
    if (nxt_state.buffer_enable_ptr_clear) begin
      dav = (nxt_state.cnt >= depth);
    end else begin
      dav = |nxt_state.flags;
    end
    nxt_state.pin_n = pin_level_n(state_ff.pin_mode, dav, pen_low);

    // Register reads show the state before this cycle's write
    nxt_state.reg_rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS: nxt_state.reg_rdata = status_word(state_ff.pin_mode, state_ff.flags);
        OFS_BUFCTL: nxt_state.reg_rdata = bufctl_word(state_ff.buffer_enable_ptr_clear,
          state_ff.buffer_oneshot_select, state_ff.buffer_trigger_depth, state_ff.cnt);
        default: nxt_state.reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '0;
      state_ff.pin_mode <= RST_PIN_MODE;
      state_ff.buffer_enable_ptr_clear <= RST_BUF_EN;
      state_ff.buffer_oneshot_select <= RST_ONESHOT;
      state_ff.buffer_trigger_depth <= RST_LEVEL;
      // Trigger pointer starts one step past the empty read pointer
      state_ff.buffer_trigger_pointer <= TRIG_STEP[5:0];
      state_ff.in_ready <= 1'b1;
      state_ff.pin_n <= 1'b1;
      state_ff.pen_s1 <= 1'b1;
      state_ff.pen_s2 <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign res_ready = state_ff.in_ready;
  assign res_rdata = state_ff.res_rdata;
  assign res_rvalid = state_ff.res_rvalid;
  assign reg_rdata = state_ff.reg_rdata;
  assign reg_rvalid = state_ff.reg_rvalid;
  assign touch_or_data_ready_pin_n = state_ff.pin_n;
  assign conv_hold = state_ff.hold;
endmodule : tarsb_top

// ===== testbench/tarsb_top_chk.sv
`timescale 1ns/10ps
module tarsb_top_chk
  import tarsb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Result port
  input wire logic res_rd,
  input wire logic res_rvalid,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // Pins
  input wire logic pen_touch_n,
  input wire logic touch_or_data_ready_pin_n,
  input wire logic conv_hold
);
  // Shadow of the writable fields, to judge readback
  logic [4:0] cfg_ff;
  logic [1:0] mode_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_ff <= {RST_BUF_EN, RST_ONESHOT, RST_LEVEL};
      mode_ff <= RST_PIN_MODE;
    end else if (reg_wr && reg_addr == OFS_BUFCTL) begin
      cfg_ff <= reg_wdata[15:11];
    end else if (reg_wr && reg_addr == OFS_STATUS) begin
      mode_ff <= reg_wdata[15:14];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_res_answer_lat: assert property (res_rd |-> ##2 res_rvalid)
    else $error("result read not answered after two cycles");
  a_res_answer_cause: assert property (res_rvalid |-> $past(res_rd, 2))
    else $error("result answer without a read");
  a_reg_answer_lat: assert property (reg_rd |=> reg_rvalid)
    else $error("register read not answered");
  a_reg_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("register answer without a read");
  a_bufctl_readback: assert property (reg_rvalid && $past(reg_addr) == OFS_BUFCTL
    |-> reg_rdata[15:11] == $past(cfg_ff) && reg_rdata[8:0] == 9'h000)
    else $error("buffer control fields read back wrong");
  a_full_not_empty: assert property (reg_rvalid && $past(reg_addr) == OFS_BUFCTL
    |-> !(reg_rdata[POS_FULL] && reg_rdata[POS_EMPTY]))
    else $error("buffer full and empty together");
  a_status_fields: assert property (reg_rvalid && $past(reg_addr) == OFS_STATUS
    |-> reg_rdata[15:14] == $past(mode_ff) && (reg_rdata & 16'h3821) == 16'h0000)
    else $error("status register fields read back wrong");
  a_pen_only_idle: assert property ((mode_ff == 2'h0 && pen_touch_n)[*4]
    |-> touch_or_data_ready_pin_n)
    else $error("pin low in pen mode without touch");
  c_res_read: cover property (res_rvalid);
  c_hold: cover property ($rose(conv_hold));
  c_full: cover property (reg_rvalid && reg_rdata[POS_FULL]);
  c_pen_pin: cover property (mode_ff == 2'h0 && !touch_or_data_ready_pin_n);
endmodule : tarsb_top_chk

bind tarsb_top tarsb_top_chk tarsb_top_chk_i (.mclk(mclk), .rstn(rstn), .res_rd(res_rd),
  .res_rvalid(res_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .pen_touch_n(pen_touch_n), .touch_or_data_ready_pin_n(touch_or_data_ready_pin_n),
  .conv_hold(conv_hold));

// ===== testbench/tarsb_host_model.sv
`timescale 1ns/10ps
module tarsb_host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
  end
  task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Released data flips so a stale word is never mistaken for a new one
    reg_wdata = ~d;
  endtask : reg_write
  task automatic reg_read(input logic [5:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    for (int n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge mclk);
    d = reg_rdata;
  endtask : reg_read
endmodule : tarsb_host_model

// ===== testbench/tarsb_top_tb.sv
`timescale 1ns/10ps
module tarsb_top_tb;
  import tarsb_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic res_valid = 1'b0;
  tarsb_kind_t res_kind = TARSB_K_X;
  tarsb_kind_t rd_kind = TARSB_K_X;
  logic [15:0] res_data = 16'h0000;
  logic res_rd = 1'b0;
  logic pen_touch_n = 1'b1;
  logic res_ready, res_rvalid, reg_wr, reg_rd, reg_rvalid, pin_n, conv_hold;
  logic [15:0] res_rdata, reg_rdata, reg_wdata, v;
  logic [5:0] reg_addr;
  int n_errors = 0;
  int checks_done = 0;
  always #20 mclk = ~mclk;
  tarsb_top tarsb_top_i (.mclk(mclk), .rstn(rstn), .res_valid(res_valid), .res_kind(res_kind),
    .res_data(res_data), .res_ready(res_ready), .res_rd(res_rd), .res_rd_kind(rd_kind),
    .res_rdata(res_rdata), .res_rvalid(res_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pen_touch_n(pen_touch_n), .touch_or_data_ready_pin_n(pin_n), .conv_hold(conv_hold));
  tarsb_host_model tarsb_host_model_i (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic push(input tarsb_kind_t k, input logic [15:0] d);
    @(negedge mclk);
    res_kind = k;
    res_data = d;
    res_valid = 1'b1;
    for (int n = 0; n < 200 && res_ready !== 1'b1; n++) @(negedge mclk);
    @(negedge mclk);
    res_valid = 1'b0;
    res_data = ~d;
  endtask : push
  task automatic pull(input tarsb_kind_t k, output logic [15:0] d);
    @(negedge mclk);
    rd_kind = k;
    res_rd = 1'b1;
    @(negedge mclk);
    res_rd = 1'b0;
    for (int n = 0; n < 4 && res_rvalid !== 1'b1; n++) @(negedge mclk);
    d = res_rdata;
    chk("result answer", {15'h0000, res_rvalid}, 16'h0001);
  endtask : pull
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
    tarsb_host_model_i.reg_read(a, v);
    chk("register answer", {15'h0000, reg_rvalid}, 16'h0001);
    chk(what, v, exp);
  endtask : rd_chk
  task automatic t_reset;
    rd_chk("status at reset", OFS_STATUS, 16'h8000);
    rd_chk("buffer ctl at reset", OFS_BUFCTL, 16'h0200);
    rd_chk("unmapped", 6'h3f, 16'h0000);
  endtask : t_reset
  task automatic t_flags;
    logic [3:0] pos [9] = '{4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1};
    for (int k = 0; k < 9; k++) begin
      push(tarsb_kind_t'(k), 16'h0c00 + 16'(k));
      repeat (3) @(negedge mclk);
      tarsb_host_model_i.reg_read(OFS_STATUS, v);
      chk("flag set", v & FLAG_MASK, 16'h0001 << pos[k]);
      chk("pin flag", {15'h0000, pin_n}, 16'h0000);
      pull(tarsb_kind_t'(k), v);
      chk("result word", v, 16'h0c00 + 16'(k));
      tarsb_host_model_i.reg_read(OFS_STATUS, v);
      chk("flag clear", v & FLAG_MASK, 16'h0000);
    end
  endtask : t_flags
  task automatic t_pen;
    tarsb_host_model_i.reg_write(OFS_STATUS, 16'h0000);
    pen_touch_n = 1'b0;
    repeat (5) @(negedge mclk);
    chk("pen pin", {15'h0000, pin_n}, 16'h0000);
    tarsb_host_model_i.reg_write(OFS_STATUS, 16'hc000);
    repeat (2) @(negedge mclk);
    chk("pen both", {15'h0000, pin_n}, 16'h0000);
    tarsb_host_model_i.reg_write(OFS_STATUS, 16'h4000);
    repeat (2) @(negedge mclk);
    chk("pen masked", {15'h0000, pin_n}, 16'h0001);
    pen_touch_n = 1'b1;
    tarsb_host_model_i.reg_write(OFS_STATUS, 16'h0000);
    repeat (5) @(negedge mclk);
    chk("pen released", {15'h0000, pin_n}, 16'h0001);
  endtask : t_pen
  task automatic t_buffer;
    tarsb_host_model_i.reg_write(OFS_STATUS, 16'h0000);
    repeat (6) @(negedge mclk);
    tarsb_host_model_i.reg_write(OFS_STATUS, 16'h4000);
    tarsb_host_model_i.reg_write(OFS_BUFCTL, 16'hb800);
    for (int i = 0; i < 66; i++) push(TARSB_K_X, 16'h5a00 + 16'(i));
    repeat (4) @(negedge mclk);
    chk("stalled", {15'h0000, res_ready}, 16'h0000);
    rd_chk("full", OFS_BUFCTL, 16'hbc00);
    rd_chk("flags frozen", OFS_STATUS, 16'h4000);
    chk("pin data", {15'h0000, pin_n}, 16'h0000);
    for (int i = 0; i < 66; i++) begin
      pull(TARSB_K_Z1, v);
      chk("oldest word", v, 16'h5a00 + 16'(i));
    end
    rd_chk("drained", OFS_BUFCTL, 16'hba00);
    chk("pin idle", {15'h0000, pin_n}, 16'h0001);
  endtask : t_buffer
  task automatic t_trigger;
    for (int c = 0; c < 8; c++) begin
      tarsb_host_model_i.reg_write(OFS_BUFCTL, 16'hc000 | (16'(c) << 11));
      for (int i = 0; i < c * 8 + 7; i++) push(TARSB_K_Y, 16'(i));
      repeat (3) @(negedge mclk);
      chk("hold early", {15'h0000, conv_hold}, 16'h0000);
      chk("pin early", {15'h0000, pin_n}, 16'h0001);
      push(TARSB_K_Y, 16'h00ff);
      repeat (3) @(negedge mclk);
      chk("hold at level", {15'h0000, conv_hold}, 16'h0001);
      chk("pin at level", {15'h0000, pin_n}, 16'h0000);
      tarsb_host_model_i.reg_write(OFS_BUFCTL, 16'h0000);
      repeat (3) @(negedge mclk);
      rd_chk("disabled", OFS_BUFCTL, 16'h0200);
      chk("hold released", {15'h0000, conv_hold}, 16'h0000);
    end
  endtask : t_trigger
  task automatic complete_run;
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    t_reset();
    t_flags();
    t_pen();
    t_buffer();
    t_trigger();
    complete_run();
  end
  initial begin
    #2400000;
    n_errors++;
    complete_run();
  end
endmodule : tarsb_top_tb
